/* core/eei_pkg.sv */
package eei_pkg;
  // ---------------------------------------------------------------
  // Event bit positions
  // ---------------------------------------------------------------
  localparam int unsigned BIT_RX_OVF   = 0;
  localparam int unsigned BIT_RX_NODSC = 1;
  localparam int unsigned BIT_TX_ABORT = 2;
  localparam int unsigned BIT_TX_DONE  = 3;
  localparam int unsigned BIT_RX_ACT   = 5;
  localparam int unsigned BIT_PKT_WAIT = 6;
  localparam int unsigned BIT_RX_DONE  = 7;
  localparam int unsigned BIT_HI_WM    = 8;
  localparam int unsigned BIT_LO_WM    = 9;
  localparam int unsigned BIT_RX_BUSE  = 13;
  localparam int unsigned BIT_TX_BUSE  = 14;
  // Implemented event bits and the software-cleared subset
  localparam logic [31:0] EVENT_MASK   = 32'h000063EF;
  localparam logic [31:0] STICKY_MASK  = 32'h000060AF;
  localparam logic [31:0] FLAGS_RESET  = 32'h00000000;
  localparam logic [31:0] ENABLE_RESET = 32'h00000000;
  // ---------------------------------------------------------------
  // Device register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_FLAGS     = 8'h00;
  localparam logic [7:0] OFF_FLAGS_CLR = 8'h04;
  localparam logic [7:0] OFF_ENABLES   = 8'h08;
  localparam logic [7:0] OFF_WMARK     = 8'h0C;
  localparam logic [7:0] OFF_CONTROL1  = 8'h10;
  localparam logic [7:0] OFF_STATUS    = 8'h14;
  // Field positions
  localparam int unsigned LO_WM_LSB    = 0;
  localparam int unsigned HI_WM_LSB    = 16;
  localparam int unsigned RX_BUFFER_COUNT_LSB   = 16;
  localparam int unsigned BUF_DEC_BIT  = 0;
  localparam logic [7:0]  RX_BUFFER_COUNT_MAX   = 8'hFF;
  localparam logic [31:0] WMARK_RESET  = 32'h00000000;
  // ---------------------------------------------------------------
  // System controller registers (host side)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_SYS_FLAG  = 8'h00;
  localparam logic [7:0] OFF_SYS_EN    = 8'h04;
  localparam logic [7:0] OFF_SYS_PRIO  = 8'h08;
  localparam int unsigned SYS_IRQ_BIT  = 28;
  localparam int unsigned PRIO_LSB     = 2;
  localparam int unsigned SUBPRIO_LSB  = 0;
endpackage

/* core/eei_if.sv */
interface eei_if (
  input wire logic clk,
  input wire logic resetn
);
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        irq;
  modport device (input addr, input wdata, input wr, input rd, output rdata, output irq);
  modport host   (output addr, output wdata, output wr, output rd, input rdata, input irq);
endinterface

/* core/eei_device.sv */
// Behaviour
// - Each event has its own enable bit
// - Flags readable whatever the enables hold
// - Request is a level while enabled pending
// - Bit 14 set on transmit DMA bus error
// - Bit 3 set when transmit status written
// - Bit 2 set on any transmit abort
// - Early collision never sets abort
// - Bit 13 set on receive DMA bus error
// - Bit 7 set per good received packet
// - Bit 6 while buffer count nonzero
// - Bit 5 set when receive FIFO holds data
// - Bit 1 on descriptor not hardware owned
// - Bit 0 on receive FIFO overflow
// - Bit 9 while count at/below low mark
// - Bit 8 while count at/above high mark
// - Sticky events cleared by software writes
// - Low mark clears after receive above it
// - Decrement bit lowers count; high mark follows
// - Packet waiting drops at count zero
// - Reset clears every sticky event flag
// - One shared vector, system flag bit 28
// - Software programs priority and subpriority
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
module eei_device
  import eei_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  resetn,
  input  wire logic  clk_en,
  eei_if.device      bus,
  input  wire logic  tx_bus_error_in,
  input  wire logic  tx_complete_in,
  input  wire logic  tx_abort_oversize,
  input  wire logic  tx_abort_underrun,
  input  wire logic  tx_abort_defer,
  input  wire logic  tx_abort_late_col,
  input  wire logic  tx_abort_retries,
  input  wire logic  tx_early_collision,
  input  wire logic  rx_bus_error_in,
  input  wire logic  rx_complete_in,
  input  wire logic  rx_fifo_not_empty,
  input  wire logic  rx_no_descriptor_in,
  input  wire logic  rx_fifo_overflow_in,
  output logic [7:0] rx_buffer_count
);
  import eei_pkg::*;

  // -------------------------------------------------------------
  // Storage
  // -------------------------------------------------------------
  // Registers
  logic [31:0] sticky;
  logic [31:0] event_enables;
  logic [7:0]  low_watermark_level;
  logic [7:0]  high_watermark_level;
  logic        low_watermark_hit;
  // Combinational views and strobes
  logic [31:0] event_flags;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic        dec_req;
  logic        rx_abort_any;
  logic [31:0] next_rdata;

  // -------------------------------------------------------------
  // Event sources
  // -------------------------------------------------------------
  // Abort causes; early collision only retries, never aborts
  // The early collision input stays unread: a retry is no event
  // Any one cause is enough; the causes are not told apart in the flag
  assign rx_abort_any = tx_abort_oversize | tx_abort_underrun | tx_abort_defer
                      | tx_abort_late_col | tx_abort_retries;

  // Hardware set vector for the sticky events
  // A source held high keeps setting its flag, so a clear then fails
  always_comb begin
    set_vec = 32'h00000000;
    set_vec[BIT_TX_BUSE]  = tx_bus_error_in;
    set_vec[BIT_TX_DONE]  = tx_complete_in;
    set_vec[BIT_TX_ABORT] = rx_abort_any;
    set_vec[BIT_RX_BUSE]  = rx_bus_error_in;
    set_vec[BIT_RX_DONE]  = rx_complete_in;
    set_vec[BIT_RX_ACT]   = rx_fifo_not_empty;
    set_vec[BIT_RX_NODSC] = rx_no_descriptor_in;
    set_vec[BIT_RX_OVF]   = rx_fifo_overflow_in;
  end

  // Clear by the alias, or by writing ones to the flag register directly
  // Both offsets clear, so either habit of software works
  always_comb begin
    clr_vec = 32'h00000000;
    if (bus.wr && (bus.addr == OFF_FLAGS || bus.addr == OFF_FLAGS_CLR)) begin
      clr_vec = bus.wdata & STICKY_MASK;
    end
  end

  // Sticky flags; a set in the clear cycle wins so no event is lost
  // Software that clears with the value it just read keeps a second
  // event of the same kind only if it lands in the clear cycle itself
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sticky <= FLAGS_RESET;
    end else if (clk_en) begin
      sticky <= ((sticky & ~clr_vec) | set_vec) & STICKY_MASK;
    end
  end

  // -------------------------------------------------------------
  // Buffer count and watermarks
  // -------------------------------------------------------------
  // Buffer count: up on good receive, down on decrement write
  // At 255 a further receive is not counted and no flag reports the loss
  // A decrement at zero is ignored rather than wrapping
  assign dec_req = bus.wr && bus.addr == OFF_CONTROL1 && bus.wdata[BUF_DEC_BIT];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_buffer_count <= 8'h00;
    end else if (clk_en) begin
      // Saturates at both ends; simultaneous up and down cancel
      if (rx_complete_in && !dec_req && rx_buffer_count != RX_BUFFER_COUNT_MAX) begin
        rx_buffer_count <= rx_buffer_count + 8'h01;
      end else if (dec_req && !rx_complete_in && rx_buffer_count != 8'h00) begin
        rx_buffer_count <= rx_buffer_count - 8'h01;
      end
    end
  end

  // Low watermark: set while at/below level, clears only after a receive
  // Raising the level above the count sets the flag one cycle later
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_watermark_hit <= 1'b0;
    end else if (clk_en) begin
      if (rx_buffer_count <= low_watermark_level) begin
        low_watermark_hit <= 1'b1;
      end else if (rx_complete_in) begin
        low_watermark_hit <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------
  // Register view
  // -------------------------------------------------------------
  // Flag view: live conditions plus sticky bits, ignoring enables
  // Live bits are rebuilt each cycle, so flag register writes cannot clear them
  always_comb begin
    event_flags = sticky;
    event_flags[BIT_PKT_WAIT] = rx_buffer_count != 8'h00;
    event_flags[BIT_HI_WM]    = rx_buffer_count >= high_watermark_level;
    event_flags[BIT_LO_WM]    = low_watermark_hit;
  end

  // Enable and watermark settings
  // Unimplemented enable bits are masked and read back as zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      event_enables        <= ENABLE_RESET;
      low_watermark_level  <= WMARK_RESET[LO_WM_LSB +: 8];
      high_watermark_level <= WMARK_RESET[HI_WM_LSB +: 8];
    end else if (clk_en && bus.wr) begin
      if (bus.addr == OFF_ENABLES) begin
        event_enables <= bus.wdata & EVENT_MASK;
      end else if (bus.addr == OFF_WMARK) begin
        low_watermark_level  <= bus.wdata[LO_WM_LSB +: 8];
        high_watermark_level <= bus.wdata[HI_WM_LSB +: 8];
      end
    end
  end

  // Read mux, unmapped reads return zero
  // Control reads as zero; only its decrement bit acts on a write
  always_comb begin
    next_rdata = 32'h00000000;
    if (bus.addr == OFF_FLAGS || bus.addr == OFF_FLAGS_CLR) begin
      next_rdata = event_flags;
    end else if (bus.addr == OFF_ENABLES) begin
      next_rdata = event_enables;
    end else if (bus.addr == OFF_WMARK) begin
      next_rdata = {8'h00, high_watermark_level, 8'h00, low_watermark_level};
    end else if (bus.addr == OFF_STATUS) begin
      next_rdata = {8'h00, rx_buffer_count, 16'h0000};
    end
  end

  // Read data the cycle after the strobe
  // Zero outside a read, so a stale value never looks like an answer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus.rdata <= 32'h00000000;
    end else if (clk_en) begin
      bus.rdata <= bus.rd ? next_rdata : 32'h00000000;
    end
  end

  // -------------------------------------------------------------
  // Interrupt request
  // -------------------------------------------------------------
  // Level request, one shared vector, registered for a clean edge
  // One cycle of latency buys a request line free of glitches
  // The system controller keeps its own flag; this line only reports
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus.irq <= 1'b0;
    end else if (clk_en) begin
      bus.irq <= |(event_flags & event_enables);
    end
  end
endmodule // eei_device

/* core/eei_host.sv */
module eei_host
  import eei_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  eei_if.host              bus,
  input  wire logic [7:0]  cmd_addr,
  input  wire logic [31:0] cmd_wdata,
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  output logic [31:0]      cmd_rdata,
  input  wire logic [7:0]  sys_addr,
  input  wire logic [31:0] sys_wdata,
  input  wire logic        sys_wr,
  input  wire logic        sys_rd,
  output logic [31:0]      sys_rdata,
  output logic             cpu_irq,
  output logic [2:0]       irq_priority,
  output logic [1:0]       irq_subpriority
);
  import eei_pkg::*;

  // -------------------------------------------------------------
  // System interrupt flag, enable and priority
  // -------------------------------------------------------------
  logic system_irq_flag;
  logic system_irq_enable;
  logic pending_d;

  // Software commands pass straight to the device bus
  assign bus.addr   = cmd_addr;
  assign bus.wdata  = cmd_wdata;
  assign bus.wr     = cmd_wr;
  assign bus.rd     = cmd_rd;
  assign cmd_rdata  = bus.rdata;

  // Flag set on request rise; set beats a software clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      system_irq_flag <= 1'b0;
      pending_d       <= 1'b0;
    end else if (clk_en) begin
      pending_d <= bus.irq;
      if (bus.irq && !pending_d) begin
        system_irq_flag <= 1'b1;
      end else if (sys_wr && sys_addr == OFF_SYS_FLAG && sys_wdata[SYS_IRQ_BIT]) begin
        system_irq_flag <= 1'b0;
      end
    end
  end

  // Enable and priority settings
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      system_irq_enable <= 1'b0;
      irq_priority      <= 3'h0;
      irq_subpriority   <= 2'h0;
    end else if (clk_en && sys_wr) begin
      if (sys_addr == OFF_SYS_EN) begin
        system_irq_enable <= sys_wdata[SYS_IRQ_BIT];
      end else if (sys_addr == OFF_SYS_PRIO) begin
        irq_priority    <= sys_wdata[PRIO_LSB +: 3];
        irq_subpriority <= sys_wdata[SUBPRIO_LSB +: 2];
      end
    end
  end

  // Priority zero never interrupts the CPU
  assign cpu_irq = system_irq_flag && system_irq_enable && irq_priority != 3'h0;

  // System register read, one cycle later
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sys_rdata <= 32'h00000000;
    end else if (clk_en) begin
      sys_rdata <= 32'h00000000;
      if (sys_rd) begin
        if (sys_addr == OFF_SYS_FLAG) begin
          sys_rdata <= 32'(system_irq_flag) << SYS_IRQ_BIT;
        end else if (sys_addr == OFF_SYS_EN) begin
          sys_rdata <= 32'(system_irq_enable) << SYS_IRQ_BIT;
        end else if (sys_addr == OFF_SYS_PRIO) begin
          sys_rdata <= {27'h0, irq_priority, irq_subpriority};
        end
      end
    end
  end
endmodule // eei_host

/* sim/eei_chk.sv */
module eei_chk
  import eei_pkg::*;
(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] en_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Shadow of the enables, so irq can be tied to them
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) en_q <= 32'h0;
    else if (wr && addr == OFF_ENABLES) en_q <= wdata & EVENT_MASK;
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  chk_idle_rdata: assert property (!rd |=> rdata == 32'h0)
    else $error("rdata not zero outside a read");
  chk_unmapped_rd: assert property (rd && addr > OFF_STATUS |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_enable_back: assert property (rd && addr == OFF_ENABLES |=> rdata == $past(en_q))
    else $error("enable readback wrong");
  chk_gate_off: assert property ((en_q == 32'h0) [*3] |-> !irq)
    else $error("irq with all enables off");
  chk_irq_cause: assert property (irq |-> $past(en_q) != 32'h0 || $past(en_q, 2) != 32'h0)
    else $error("irq without any enable");
  // Sticky-only enables cannot drop without a write two cycles back
  chk_irq_level: assert property (
    irq && !wr && !$past(wr) && (en_q & ~STICKY_MASK) == 32'h0 |=> irq)
    else $error("irq dropped without a clear");
  chk_flag_vs_irq: assert property (
    rd && addr == OFF_FLAGS && irq && !$past(wr)
    && (en_q & ~STICKY_MASK) == 32'h0 |=> (rdata & en_q) != 32'h0)
    else $error("irq high but no enabled flag read");
  chk_reset_quiet: assert property ($rose(resetn) |-> !irq && rdata == 32'h0)
    else $error("outputs not cleared by reset");
endmodule // eei_chk

/* sim/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import eei_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [12:0] ev = '0;
  logic [7:0]  ad = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [1:0]  wrs = 2'b00;
  logic [1:0]  rds = 2'b00;
  logic [31:0] cmd_rdata, sys_rdata;
  logic [2:0]  irq_priority;
  logic [1:0]  irq_subpriority;
  logic [7:0]  count;
  logic        cpu_irq;
  logic        ce = 1'b1;
  int          mismatches = 0;
  int          compares = 0;
  always #2.5 clk = ~clk;
  // ------------------------------------------------------------
  // Both ends joined; software ports share address and data
  // ------------------------------------------------------------
  eei_if eei_if_i (.clk(clk), .resetn(resetn));
  eei_device eei_device_i (.clk(clk), .resetn(resetn), .clk_en(ce), .bus(eei_if_i),
    .tx_bus_error_in(ev[0]), .tx_complete_in(ev[1]), .tx_abort_oversize(ev[2]),
    .tx_abort_underrun(ev[3]), .tx_abort_defer(ev[4]), .tx_abort_late_col(ev[5]),
    .tx_abort_retries(ev[6]), .tx_early_collision(ev[7]), .rx_bus_error_in(ev[8]),
    .rx_complete_in(ev[9]), .rx_fifo_not_empty(ev[10]), .rx_no_descriptor_in(ev[11]),
    .rx_fifo_overflow_in(ev[12]), .rx_buffer_count(count));
  eei_host eei_host_i (.clk(clk), .resetn(resetn), .clk_en(ce), .bus(eei_if_i),
    .cmd_addr(ad), .cmd_wdata(wd), .cmd_wr(wrs[0]), .cmd_rd(rds[0]), .cmd_rdata(cmd_rdata),
    .sys_addr(ad), .sys_wdata(wd), .sys_wr(wrs[1]), .sys_rd(rds[1]), .sys_rdata(sys_rdata),
    .cpu_irq(cpu_irq), .irq_priority(irq_priority), .irq_subpriority(irq_subpriority));
  eei_chk eei_chk_i (.clk(clk), .resetn(resetn), .addr(eei_if_i.addr),
    .wdata(eei_if_i.wdata), .wr(eei_if_i.wr), .rd(eei_if_i.rd),
    .rdata(eei_if_i.rdata), .irq(eei_if_i.irq));
  // ------------------------------------------------------------
  // Bus and compare helpers; s selects device (0) or system (1)
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input int s, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    ad <= a;
    wd <= d;
    wrs[s] <= 1'b1;
    @(posedge clk);
    wrs <= 2'b00;
  endtask
  // Read data only stand in the cycle after the strobe
  task automatic rchk(input int s, input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    ad <= a;
    rds[s] <= 1'b1;
    @(posedge clk);
    rds <= 2'b00;
    #1 check($sformatf("reg %h", a), s ? sys_rdata : cmd_rdata, e);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    hold(3);
    rchk(0, OFF_FLAGS, 32'h300);
    rchk(0, OFF_ENABLES, 32'h0);
    rchk(0, OFF_STATUS, 32'h0);
  endtask
  // Receive done is left out here as it moves the count
  task automatic t_sticky;
    int          b[13] = '{14, 3, 2, 2, 2, 2, 2, -1, 13, 7, 5, 1, 0};
    logic [31:0] m;
    for (int i = 0; i < 13; i++) begin
      if (i == 9) continue;
      m = (b[i] < 0) ? 32'h0 : 32'h1 << b[i];
      pulse(i);
      rchk(0, OFF_FLAGS, m | 32'h300);
      check("irq", eei_if_i.irq, 1'b0);
      wreg(0, (i % 2) ? OFF_FLAGS : OFF_FLAGS_CLR, m);
      rchk(0, OFF_FLAGS, 32'h300);
    end
  endtask
  task automatic t_irq;
    wreg(0, OFF_ENABLES, 32'h8);
    pulse(1);
    hold(4);
    check("irq", eei_if_i.irq, 1'b1);
    rchk(0, OFF_FLAGS, 32'h308);
    wreg(1, OFF_SYS_PRIO, 32'h16);
    wreg(1, OFF_SYS_EN, 32'h1000_0000);
    hold(2);
    check("prio", {irq_priority, irq_subpriority}, 5'h16);
    rchk(1, OFF_SYS_PRIO, 32'h16);
    rchk(1, OFF_SYS_FLAG, 32'h1000_0000);
    wreg(0, OFF_FLAGS_CLR, 32'h8);
    hold(4);
    check("irq", eei_if_i.irq, 1'b0);
    check("cpu", cpu_irq, 1'b1);
    wreg(1, OFF_SYS_FLAG, 32'h1000_0000);
    hold(2);
    check("cpu", cpu_irq, 1'b0);
    pulse(2);
    hold(4);
    check("irq", eei_if_i.irq, 1'b0);
    wreg(0, OFF_ENABLES, 32'h4);
    hold(4);
    check("irq", eei_if_i.irq, 1'b1);
    wreg(0, OFF_FLAGS, 32'h4);
  endtask
  // Low mark 1, high mark 3
  task automatic t_count;
    wreg(0, OFF_WMARK, 32'h0003_0001);
    pulse(9);
    rchk(0, OFF_FLAGS, 32'h2C0);
    pulse(9);
    pulse(9);
    rchk(0, OFF_FLAGS, 32'h1C0);
    rchk(0, OFF_STATUS, 32'h0003_0000);
    check("count", count, 8'h03);
    wreg(0, OFF_FLAGS, 32'h300);
    rchk(0, OFF_FLAGS, 32'h1C0);
    wreg(0, OFF_CONTROL1, 32'h1);
    rchk(0, OFF_FLAGS, 32'h0C0);
    wreg(0, OFF_CONTROL1, 32'h1);
    rchk(0, OFF_FLAGS, 32'h2C0);
    wreg(0, OFF_CONTROL1, 32'h1);
    rchk(0, OFF_FLAGS, 32'h280);
    wreg(0, OFF_FLAGS_CLR, 32'h80);
    rchk(0, OFF_FLAGS, 32'h200);
    rchk(0, 8'h40, 32'h0);
  endtask
  // Clock enable low: an event pulse while frozen leaves no trace
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    pulse(1);
    @(posedge clk);
    ce <= 1'b1;
    rchk(0, OFF_FLAGS, 32'h300);
  endtask
  // Second reset lands with an enabled flag pending and irq high
  task automatic t_mid_reset;
    wreg(0, OFF_ENABLES, 32'h4000);
    pulse(0);
    hold(2);
    check("irq", eei_if_i.irq, 1'b1);
    rchk(0, OFF_FLAGS, 32'h4200);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    hold(1);
    check("irq", eei_if_i.irq, 1'b0);
    t_reset;
  endtask
  task automatic stop_test;
    if (mismatches == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_reset;
    t_freeze;
    t_sticky;
    t_irq;
    t_count;
    t_mid_reset;
    stop_test;
  end
endmodule // tb
